// file: bench/tb.sv
// self-checking bench for the t1 event interrupt status block
`timescale 1ns/1ns
`default_nettype none
// ****
// bench
// ****
module tb
    import teis_pkg::*;
;
    localparam logic [4:0] W = TEIS_OFS_WRAP_WORD;
    localparam logic [4:0] L = TEIS_OFS_LINK_WORD;
    localparam int LOOPN = 20;
    localparam int DEB = 4;
    logic clock = 1'b0, srst = 1'b1, host_rd = 1'b0, host_rvalid;
    logic [4:0] host_addr = 5'h00;
    logic [7:0] host_rdata, counter_wrap = 8'h00;
    logic [7:0] wrap_unmask = 8'hff, link_unmask = 8'hff;
    logic link_a = 1'b0, link_b = 1'b0, loop_code = 1'b0;
    logic one_sec = 1'b0, five_sec = 1'b0, bom_strobe = 1'b0, sig_deb = 1'b0;
    logic [13:0] bom_pattern = 14'h0000;
    logic [3:0] sig_bits = 4'h0;
    int num_errors = 0;
    int n_tests = 0;
    // short counts keep the run brief
    teis_status #(.LOOP_CYCLES(LOOPN), .SIG_DEBOUNCE(DEB), .SIG_WIDTH(4)) DUT (
        .clock(clock), .srst(srst), .host_addr(host_addr), .host_rd(host_rd),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .counter_wrap(counter_wrap), .wrap_unmask(wrap_unmask),
        .link_unmask(link_unmask), .link_ctrl_a_irq(link_a),
        .link_ctrl_b_irq(link_b), .loop_code_present(loop_code),
        .one_second_status(one_sec), .five_second_status(five_sec),
        .bom_strobe(bom_strobe), .bom_pattern(bom_pattern),
        .signaling_bits(sig_bits), .signaling_debounce_enable(sig_deb));
    always #4 clock = ~clock;
    // every input change lands 1 ns after an edge
    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // idle cycle after each read so the strobe never toggles twice at once
    task automatic rdc(input logic [4:0] a, input logic [7:0] e, string nm);
        host_addr = a;
        host_rd = 1'b1;
        tick();
        chk("rvalid", {7'h00, host_rvalid}, 8'h01);
        chk(nm, host_rdata, e);
        host_rd = 1'b0;
        tick();
    endtask : rdc
    task automatic pl(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pl
    task automatic t_reset();
        rdc(W, TEIS_STATUS_RESET, "wrap reset");
        rdc(L, TEIS_STATUS_RESET, "link reset");
        rdc(5'h00, 8'h00, "unmapped");
        $display("test reset done");
    endtask : t_reset
    task automatic t_wrap();
        wrap_unmask = 8'h00;
        counter_wrap = 8'hff;
        tick();
        counter_wrap = 8'h00;
        rdc(W, 8'h00, "masked wrap");
        wrap_unmask = 8'hff;
        for (int i = 0; i < 8; i++) begin
            counter_wrap = 8'h01 << i;
            tick();
            counter_wrap = 8'h00;
            rdc(W, 8'h01 << i, "wrap bit");
            rdc(W, 8'h00, "wrap clear");
        end
        $display("test wrap done");
    endtask : t_wrap
    // event lands in the very cycle of a read; back to back reads follow
    task automatic t_race();
        host_addr = W;
        host_rd = 1'b1;
        counter_wrap = 8'h81;
        tick();
        counter_wrap = 8'h00;
        chk("race first", host_rdata, 8'h00);
        tick();
        host_rd = 1'b0;
        chk("race second", host_rdata, 8'h81);
        tick();
        $display("test race done");
    endtask : t_race
    task automatic t_link();
        link_unmask = 8'h00;
        pl(link_a);
        rdc(L, 8'h00, "masked a");
        link_unmask = 8'hff;
        pl(link_a);
        rdc(L, 8'h40, "link a");
        pl(link_b);
        rdc(L, 8'h20, "link b");
        one_sec = 1'b1;
        tick();
        rdc(L, 8'h08, "one second");
        rdc(L, 8'h00, "one second held");
        pl(five_sec);
        rdc(L, 8'h04, "five second");
        sig_bits = 4'h5;
        tick();
        rdc(L, 8'h01, "signaling");
        one_sec = 1'b0;
        $display("test link done");
    endtask : t_link
    task automatic t_debounce();
        sig_deb = 1'b1;
        sig_bits = 4'ha;
        repeat (DEB - 2) tick();
        sig_bits = 4'h5;
        repeat (2 * DEB) tick();
        rdc(L, 8'h00, "glitch");
        sig_bits = 4'ha;
        repeat (2 * DEB) tick();
        rdc(L, 8'h01, "debounced");
        sig_deb = 1'b0;
        $display("test debounce done");
    endtask : t_debounce
    task automatic t_loop();
        loop_code = 1'b1;
        repeat (LOOPN / 2) tick();
        loop_code = 1'b0;
        tick();
        rdc(L, 8'h00, "short code");
        loop_code = 1'b1;
        repeat (LOOPN + 4) tick();
        rdc(L, 8'h10, "loop code");
        rdc(L, 8'h00, "same burst");
        loop_code = 1'b0;
        $display("test loop done");
    endtask : t_loop
    task automatic bom(input logic [13:0] p, input int n);
        repeat (n) begin
            bom_pattern = p;
            bom_strobe = 1'b1;
            tick();
            bom_strobe = 1'b0;
            tick();
        end
    endtask : bom
    task automatic t_bom();
        bom(14'h3f84, 7);
        rdc(L, 8'h00, "seven of ten");
        bom(14'h3f84, 1);
        rdc(L, 8'h02, "accepted");
        bom(14'h3f84, 2);
        rdc(L, 8'h00, "same message");
        bom(14'h3f88, 7);
        rdc(L, 8'h00, "new seven");
        bom(14'h3f88, 1);
        rdc(L, 8'h02, "new message");
        bom(14'h0000, 10);
        rdc(L, 8'h00, "bad form");
        $display("test message done");
    endtask : t_bom
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge clock);
        #1 srst = 1'b0;
        t_reset();
        t_wrap();
        t_race();
        t_link();
        t_debounce();
        t_loop();
        t_bom();
        give_verdict();
    end
    // about twelve times the expected run of some 205 cycles
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// file: bench/teis_status_properties.sv
// assertion checker for the t1 event interrupt status block
`timescale 1ns/1ns
`default_nettype none
// ****
// checker
// ****
module teis_chk
    import teis_pkg::*;
#(
    parameter int LOOP_CYCLES  = 20,
    parameter int SIG_DEBOUNCE = 4,
    parameter int SIG_WIDTH    = 4
) (
    input wire logic                 clock,
    input wire logic                 srst,
    input wire logic [4:0]           host_addr,
    input wire logic                 host_rd,
    input wire logic [7:0]           host_rdata,
    input wire logic                 host_rvalid,
    input wire logic [7:0]           counter_wrap,
    input wire logic [7:0]           wrap_unmask,
    input wire logic [7:0]           link_unmask,
    input wire logic                 link_ctrl_a_irq,
    input wire logic                 link_ctrl_b_irq,
    input wire logic                 one_second_status,
    input wire logic                 five_second_status,
    input wire logic [SIG_WIDTH-1:0] signaling_bits,
    input wire logic                 signaling_debounce_enable
);
    // read strobes decoded per word
    wire logic rd_w = host_rd && host_addr == TEIS_OFS_WRAP_WORD;
    wire logic rd_l = host_rd && host_addr == TEIS_OFS_LINK_WORD;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // an unmasked event is seen by the read that follows it
    chk_framing_wrap: assert property (counter_wrap[7] && wrap_unmask[7]
        ##1 rd_w |=> host_rdata[7]) else $error("framing wrap lost");
    // back to back reads: the second shows only what came meanwhile
    chk_read_clear: assert property (rd_w ##1 rd_w |=> host_rdata ==
        ($past(counter_wrap, 2) & $past(wrap_unmask, 2)))
        else $error("wrap word not cleared by read");
    chk_link_a: assert property (link_ctrl_a_irq && link_unmask[6]
        ##1 rd_l |=> host_rdata[6]) else $error("link a event lost");
    chk_link_b: assert property (link_ctrl_b_irq && link_unmask[5]
        ##1 rd_l |=> host_rdata[5]) else $error("link b event lost");
    // the timer bits follow the rising edge, not the level
    chk_one_sec: assert property ($rose(one_second_status)
        && link_unmask[3] ##1 rd_l |=> host_rdata[3])
        else $error("one second event lost");
    chk_five_sec: assert property ($rose(five_second_status)
        && link_unmask[2] ##1 rd_l |=> host_rdata[2])
        else $error("five second event lost");
    // reference resets to zero, so skip the cycle right after reset
    chk_sig_change: assert property ($changed(signaling_bits)
        && !$past(srst) && !signaling_debounce_enable && link_unmask[0]
        ##1 rd_l |=> host_rdata[0]) else $error("signaling change lost");
    chk_unused_bit: assert property (host_rvalid && $past(host_addr) ==
        TEIS_OFS_LINK_WORD |-> !host_rdata[7]) else $error("unused bit set");
    cov_back_to_back: cover property (rd_w ##1 rd_w);
    cov_link_read: cover property (host_rvalid && host_rdata[6]);
    cov_message: cover property (host_rvalid && host_rdata[1]);
endmodule : teis_chk
bind teis_status teis_chk #(.LOOP_CYCLES(LOOP_CYCLES),
    .SIG_DEBOUNCE(SIG_DEBOUNCE), .SIG_WIDTH(SIG_WIDTH)) u_chk (
    .clock(clock), .srst(srst), .host_addr(host_addr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .counter_wrap(counter_wrap), .wrap_unmask(wrap_unmask),
    .link_unmask(link_unmask), .link_ctrl_a_irq(link_ctrl_a_irq),
    .link_ctrl_b_irq(link_ctrl_b_irq), .one_second_status(one_second_status),
    .five_second_status(five_second_status),
    .signaling_bits(signaling_bits),
    .signaling_debounce_enable(signaling_debounce_enable));
`default_nettype wire

// file: src/teis_pkg.sv
// constants shared by the t1 event interrupt status block
package teis_pkg;
    // host port word offsets
    localparam logic [4:0] TEIS_OFS_WRAP_WORD = 5'h1d;
    localparam logic [4:0] TEIS_OFS_LINK_WORD = 5'h1e;
    // reset value of both status words
    localparam logic [7:0] TEIS_STATUS_RESET  = 8'h00;
    // field positions, counter wrap word
    localparam int TEIS_FRAMING_ERR_BIT   = 7;
    localparam int TEIS_CHECKSUM_ERR_BIT  = 6;
    localparam int TEIS_OUT_OF_FRAME_BIT  = 5;
    localparam int TEIS_ALIGN_CHANGE_BIT  = 4;
    localparam int TEIS_BIPOLAR_VIOL_BIT  = 3;
    localparam int TEIS_PATTERN_ERR_BIT   = 2;
    localparam int TEIS_PATTERN_MF_BIT    = 1;
    localparam int TEIS_MF_UNSYNC_BIT     = 0;
    // field positions, link and timer word
    localparam int TEIS_UNUSED_BIT        = 7;
    localparam int TEIS_LINK_CTRL_A_BIT   = 6;
    localparam int TEIS_LINK_CTRL_B_BIT   = 5;
    localparam int TEIS_LOOPBACK_BIT      = 4;
    localparam int TEIS_ONE_SECOND_BIT    = 3;
    localparam int TEIS_FIVE_SECOND_BIT   = 2;
    localparam int TEIS_BIT_MESSAGE_BIT   = 1;
    localparam int TEIS_SIGNALING_BIT     = 0;
    // loop code persistence time
    localparam int TEIS_CLK_KHZ           = 125000;
    localparam int TEIS_LOOP_TIME_MS      = 48;
    localparam int TEIS_LOOP_CYCLES       = TEIS_LOOP_TIME_MS * TEIS_CLK_KHZ;
    // bit oriented message acceptance window
    localparam int TEIS_BOM_NEEDED        = 8;
    localparam int TEIS_BOM_WINDOW        = 10;
    // default signaling debounce in cycles
    localparam int TEIS_SIG_DEBOUNCE      = 16;
endpackage : teis_pkg

// file: src/teis_pkg_unused_guard.sv
// intentionally empty compile unit kept minimal
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: src/teis_status.sv
// interrupt status words two and three for t1 mode
//
// Summary of operation
// - framing error wrap sets word two bit 7 if unmasked; read clears
// - checksum error wrap sets word two bit 6 if unmasked; read clears
// - out of frame counter wrap sets word two bit 5 if unmasked; read clears
// - alignment change counter wrap sets word two bit 4; read clears
// - bipolar violation counter wrap sets word two bit 3; read clears
// - test pattern error counter wrap sets word two bit 2; read clears
// - test pattern multiframe counter wrap sets word two bit 1
// - multiframe unsync counter wrap sets word two bit 0; read clears
// - unmasked link controller a interrupt sets word three bit 6
// - unmasked link controller b interrupt sets word three bit 5
// - loop code present continuously 48 ms sets word three bit 4
// - one second status rising edge sets word three bit 3
// - five second status rising edge sets word three bit 2
// - newly accepted differing bit message sets word three bit 1
// - message accepted only when seen 8 of last 10 positions
// - signaling pattern change, optionally debounced, sets word three bit 0
`timescale 1ns/1ns
`default_nettype none
module teis_status
    import teis_pkg::*;
#(
    parameter int LOOP_CYCLES  = TEIS_LOOP_CYCLES,
    parameter int SIG_DEBOUNCE = TEIS_SIG_DEBOUNCE,
    parameter int SIG_WIDTH    = 4
) (
    input  wire logic                 clock,
    input  wire logic                 srst,
    // host port
    input  wire logic [4:0]           host_addr,
    input  wire logic                 host_rd,
    output var  logic [7:0]           host_rdata,
    output var  logic                 host_rvalid,
    // counter wrap pulses, bit order as in the wrap word
    input  wire logic [7:0]           counter_wrap,
    input  wire logic [7:0]           wrap_unmask,
    input  wire logic [7:0]           link_unmask,
    // event sources
    input  wire logic                 link_ctrl_a_irq,
    input  wire logic                 link_ctrl_b_irq,
    input  wire logic                 loop_code_present,
    input  wire logic                 one_second_status,
    input  wire logic                 five_second_status,
    input  wire logic                 bom_strobe,
    input  wire logic [13:0]          bom_pattern,
    input  wire logic [SIG_WIDTH-1:0] signaling_bits,
    input  wire logic                 signaling_debounce_enable
);

    // ****************************************************************
    // host read decode
    // ****************************************************************
    logic rd_wrap;
    logic rd_link;
    assign rd_wrap = host_rd && (host_addr == TEIS_OFS_WRAP_WORD);
    assign rd_link = host_rd && (host_addr == TEIS_OFS_LINK_WORD);

    // ****************************************************************
    // loop code persistence timer
    // ****************************************************************
    localparam int LW = $clog2(LOOP_CYCLES + 1);
    logic [LW-1:0] loop_cnt_q;
    logic [LW-1:0] loop_cnt_d;
    logic          loop_evt;

    // counter saturates so one continuous burst raises only one event
    always_comb begin
        loop_cnt_d = loop_cnt_q;
        loop_evt   = 1'b0;
        if (!loop_code_present) begin
            loop_cnt_d = '0;
        end else if (loop_cnt_q != LW'(LOOP_CYCLES)) begin
            loop_cnt_d = loop_cnt_q + LW'(1);
            loop_evt   = (loop_cnt_d == LW'(LOOP_CYCLES));
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            loop_cnt_q <= '0;
        end else begin
            loop_cnt_q <= loop_cnt_d;
        end
    end

    // ****************************************************************
    // timer edge detection
    // ****************************************************************
    logic one_sec_prev_q;
    logic five_sec_prev_q;
    logic one_sec_evt;
    logic five_sec_evt;
    assign one_sec_evt  = one_second_status && !one_sec_prev_q;
    assign five_sec_evt = five_second_status && !five_sec_prev_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            one_sec_prev_q  <= 1'b0;
            five_sec_prev_q <= 1'b0;
        end else begin
            one_sec_prev_q  <= one_second_status;
            five_sec_prev_q <= five_second_status;
        end
    end

    // ****************************************************************
    // bit oriented message filter
    // ****************************************************************
    localparam int HW = $clog2(TEIS_BOM_WINDOW);
    localparam int CW = $clog2(TEIS_BOM_WINDOW + 1);
    logic [13:0]   bom_hist_q [TEIS_BOM_WINDOW];
    logic [13:0]   bom_hist_d [TEIS_BOM_WINDOW];
    logic [HW-1:0] bom_ptr_q;
    logic [HW-1:0] bom_ptr_d;
    logic [13:0]   bom_acc_q;
    logic [13:0]   bom_acc_d;
    logic          bom_acc_vld_q;
    logic          bom_acc_vld_d;
    logic [CW-1:0] bom_hits;
    logic          bom_form_ok;
    logic          bom_evt;

    // only the 11111110xxxxx0 form counts as a message
    assign bom_form_ok = (bom_pattern[13:6] == 8'hfe) && !bom_pattern[0];

    // the new position is written over the oldest, then all ten compared
    always_comb begin
        bom_hist_d    = bom_hist_q;
        bom_ptr_d     = bom_ptr_q;
        bom_acc_d     = bom_acc_q;
        bom_acc_vld_d = bom_acc_vld_q;
        bom_hits      = '0;
        bom_evt       = 1'b0;
        if (bom_strobe) begin
            bom_hist_d[bom_ptr_q] = bom_pattern;
            bom_ptr_d = (bom_ptr_q == HW'(TEIS_BOM_WINDOW - 1)) ?
                        '0 : bom_ptr_q + HW'(1);
            for (int i = 0; i < TEIS_BOM_WINDOW; i++) begin
                if (bom_hist_d[i] == bom_pattern) begin
                    bom_hits = bom_hits + CW'(1);
                end
            end
            if (bom_form_ok && (bom_hits >= CW'(TEIS_BOM_NEEDED)) &&
                (!bom_acc_vld_q || (bom_acc_q != bom_pattern))) begin
                bom_acc_d     = bom_pattern;
                bom_acc_vld_d = 1'b1;
                bom_evt       = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < TEIS_BOM_WINDOW; i++) begin
                bom_hist_q[i] <= '0;
            end
            bom_ptr_q     <= '0;
            bom_acc_q     <= '0;
            bom_acc_vld_q <= 1'b0;
        end else begin
            bom_hist_q    <= bom_hist_d;
            bom_ptr_q     <= bom_ptr_d;
            bom_acc_q     <= bom_acc_d;
            bom_acc_vld_q <= bom_acc_vld_d;
        end
    end

    // ****************************************************************
    // signaling change detection with optional debounce
    // ****************************************************************
    localparam int DW = $clog2(SIG_DEBOUNCE + 1);
    logic [SIG_WIDTH-1:0] sig_ref_q;
    logic [SIG_WIDTH-1:0] sig_ref_d;
    logic [SIG_WIDTH-1:0] sig_cand_q;
    logic [SIG_WIDTH-1:0] sig_cand_d;
    logic [DW-1:0]        sig_cnt_q;
    logic [DW-1:0]        sig_cnt_d;
    logic                 sig_evt;

    // a changed pattern must hold SIG_DEBOUNCE + 1 cycles when debounce is on;
    // glitches shorter than that are swallowed, costing report latency
    always_comb begin
        sig_ref_d  = sig_ref_q;
        sig_cand_d = signaling_bits;
        sig_cnt_d  = '0;
        sig_evt    = 1'b0;
        if (signaling_bits != sig_ref_q) begin
            if (!signaling_debounce_enable) begin
                sig_ref_d = signaling_bits;
                sig_evt   = 1'b1;
            end else if (signaling_bits != sig_cand_q) begin
                sig_cnt_d = '0;
            end else if (sig_cnt_q == DW'(SIG_DEBOUNCE - 1)) begin
                sig_ref_d = signaling_bits;
                sig_evt   = 1'b1;
            end else begin
                sig_cnt_d = sig_cnt_q + DW'(1);
            end
        end
    end

    // reference starts at all zero; a nonzero pattern after reset reports
    always_ff @(posedge clock) begin
        if (srst) begin
            sig_ref_q  <= '0;
            sig_cand_q <= '0;
            sig_cnt_q  <= '0;
        end else begin
            sig_ref_q  <= sig_ref_d;
            sig_cand_q <= sig_cand_d;
            sig_cnt_q  <= sig_cnt_d;
        end
    end

    // ****************************************************************
    // sticky status words
    // ****************************************************************
    logic [7:0] wrap_q;
    logic [7:0] wrap_d;
    logic [7:0] link_q;
    logic [7:0] link_d;
    logic [7:0] wrap_set;
    logic [7:0] link_evt;
    logic [7:0] link_set;

    // per-bit wrap gating by mask
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_wrap
            assign wrap_set[g] = counter_wrap[g]
                                 && wrap_unmask[g];
        end
    endgenerate

    always_comb begin
        link_evt = 8'h00;
        link_evt[TEIS_LINK_CTRL_A_BIT] = link_ctrl_a_irq;
        link_evt[TEIS_LINK_CTRL_B_BIT] = link_ctrl_b_irq;
        link_evt[TEIS_LOOPBACK_BIT]    = loop_evt;
        link_evt[TEIS_ONE_SECOND_BIT]  = one_sec_evt;
        link_evt[TEIS_FIVE_SECOND_BIT] = five_sec_evt;
        link_evt[TEIS_BIT_MESSAGE_BIT] = bom_evt;
        link_evt[TEIS_SIGNALING_BIT]   = sig_evt;
        link_set = link_evt & link_unmask;
        link_set[TEIS_UNUSED_BIT] = 1'b0;
    end

    // read clears, but a set in the same cycle wins
    always_comb begin
        wrap_d = (rd_wrap ? 8'h00 : wrap_q) | wrap_set;
        link_d = (rd_link ? 8'h00 : link_q) | link_set;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wrap_q <= TEIS_STATUS_RESET;
            link_q <= TEIS_STATUS_RESET;
        end else begin
            wrap_q <= wrap_d;
            link_q <= link_d;
        end
    end

    // ****************************************************************
    // read data, one cycle after the read strobe
    // ****************************************************************
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        if (rd_wrap) begin
            rdata_d = wrap_q;
        end else if (rd_link) begin
            rdata_d = link_q;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            host_rdata  <= 8'h00;
            host_rvalid <= 1'b0;
        end else begin
            host_rdata  <= rdata_d;
            host_rvalid <= host_rd;
        end
    end

endmodule : teis_status
`default_nettype wire
